// *** rtl/nvsram_host.sv ***
// host controller that drives the asynchronous non-volatile static memory pins
`timescale 1ns/100ps
`default_nettype none
module nvsram_host
  import nvsram_host_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // user requests
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  input wire logic store_req,
  output logic store_active,
  // memory pins
  output logic select_n,
  output logic write_n,
  output logic out_en_n,
  output logic [ADDR_W-1:0] byte_address,
  input wire logic [DATA_W-1:0] data_bus_in,
  output logic [DATA_W-1:0] data_bus_out,
  output logic data_bus_oe,
  input wire logic store_busy_n_in,
  output logic store_busy_n_out,
  output logic store_busy_n_oe
);
  host_state_e state_q;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_count;
  logic tmr_done;
  logic tmr_running;
  logic busy_seen_q;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = (n < 1) ? {{(CNT_W-1){1'b0}}, 1'b1} : CNT_W'(n);
  endfunction : cyc

  nvsram_wait_timer u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done),
    .running(tmr_running)
  );

  // timer loads on every state entry that waits
  always_comb begin
    tmr_load = 1'b0;
    tmr_count = '0;
    case (state_q)
      ST_IDLE: begin
        if (store_req) begin
          tmr_load = 1'b1;
          tmr_count = cyc(STORE_REQ_CYC);
        end else if (req_valid && store_busy_n_in) begin
          tmr_load = 1'b1;
          tmr_count = req_write ? cyc(WRITE_WAIT_CYC) : cyc(READ_WAIT_CYC);
        end
      end
      ST_REQ: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_count = cyc(STORE_TIME_CYC);
        end
      end
      default: begin
        tmr_load = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (store_req) begin
            state_q <= ST_REQ;
          end else if (req_valid && store_busy_n_in) begin
            state_q <= req_write ? ST_WRITE : ST_READ;
          end
        end
        ST_READ: begin
          if (tmr_done || !store_busy_n_in) begin
            state_q <= ST_GAP;
          end
        end
        ST_WRITE: begin
          if (tmr_done) begin
            state_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          state_q <= ST_IDLE;
        end
        ST_REQ: begin
          if (tmr_done) begin
            state_q <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (!tmr_running && !tmr_load && store_busy_n_in) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // pin drive: strobes and address straight from flip-flops
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      select_n <= 1'b1;
      write_n <= 1'b1;
      out_en_n <= 1'b1;
      byte_address <= '0;
      data_bus_out <= '0;
      data_bus_oe <= 1'b0;
    end else if (state_q == ST_IDLE && !store_req && req_valid && store_busy_n_in) begin
      select_n <= 1'b0;
      byte_address <= req_addr;
      write_n <= ~req_write;
      out_en_n <= req_write;
      data_bus_out <= req_wdata;
      data_bus_oe <= req_write;
    end else if ((state_q == ST_READ && (tmr_done || !store_busy_n_in)) ||
                 (state_q == ST_WRITE && tmr_done)) begin
      select_n <= 1'b1;
      write_n <= 1'b1;
      out_en_n <= 1'b1;
    end else if (state_q == ST_GAP) begin
      data_bus_oe <= 1'b0;
    end
  end

  // store request drive and busy tracking
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      store_busy_n_out <= 1'b0;
      store_busy_n_oe <= 1'b0;
      busy_seen_q <= 1'b0;
    end else begin
      store_busy_n_out <= 1'b0;
      if (state_q == ST_IDLE && store_req) begin
        store_busy_n_oe <= 1'b1;
      end else if (state_q == ST_REQ && tmr_done) begin
        store_busy_n_oe <= 1'b0;
      end
      busy_seen_q <= !store_busy_n_in;
    end
  end

  // user answers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      req_ready <= 1'b0;
      store_active <= 1'b0;
    end else begin
      rsp_valid <= (state_q == ST_READ && tmr_done && store_busy_n_in) ||
                   (state_q == ST_WRITE && tmr_done);
      if (state_q == ST_READ && tmr_done) begin
        rsp_rdata <= data_bus_in;
      end
      req_ready <= (state_q == ST_IDLE && !store_req && req_valid && store_busy_n_in);
      store_active <= (state_q == ST_REQ) || (state_q == ST_BUSY) || busy_seen_q;
    end
  end

  a_read_strobes: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_READ) |-> (!select_n && !out_en_n && write_n))
    else $error("read strobes wrong");
  a_write_strobes: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_WRITE) |-> (!select_n && !write_n && out_en_n && data_bus_oe))
    else $error("write strobes wrong");
  a_write_addr_stable: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!write_n && $past(!write_n)) |-> $stable(byte_address))
    else $error("address moved in write");
  a_write_data_stable: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!write_n && $past(!write_n)) |-> $stable(data_bus_out))
    else $error("data moved in write");
  a_no_contention: assert property (@(posedge sys_clk) disable iff (!rst_n)
    data_bus_oe |-> out_en_n)
    else $error("bus contention");
  a_access_idle_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_BUSY) |-> (select_n && write_n))
    else $error("access during store");
  a_store_pull: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_IDLE && store_req) |=> (store_busy_n_oe && !store_busy_n_out))
    else $error("store request not driven");
  a_select_deassert: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_GAP) |-> select_n)
    else $error("select not released");
  c_read: cover property (@(posedge sys_clk) disable iff (!rst_n) rsp_valid && write_n);
  c_write: cover property (@(posedge sys_clk) disable iff (!rst_n) state_q == ST_WRITE);
  c_store: cover property (@(posedge sys_clk) disable iff (!rst_n) state_q == ST_BUSY);
endmodule : nvsram_host
`default_nettype wire

// *** rtl/nvsram_host_pkg.sv ***
// constants for the host-side controller of the non-volatile static memory
package nvsram_host_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int CLK_MHZ = 40;
  localparam int CLK_PERIOD_NS = 25;
  // timing figures in ns, store time in ms, device speed grade assumed 45 ns
  localparam int ADDRESS_ACCESS_DELAY_NS = 45;
  localparam int SELECT_ACCESS_DELAY_NS = 45;
  localparam int OUTPUT_ENABLE_ACCESS_DELAY_NS = 20;
  localparam int DATA_SETUP_INTERVAL_NS = 30;
  localparam int WRITE_TO_HIGHZ_DELAY_NS = 20;
  localparam int STORE_REQUEST_DELAY_NS = 25000;
  localparam int STORE_TIME_MS = 10;
  // cycle counts, least times rounded up
  localparam int READ_WAIT_CYC =
    (((SELECT_ACCESS_DELAY_NS > OUTPUT_ENABLE_ACCESS_DELAY_NS) ?
      SELECT_ACCESS_DELAY_NS : OUTPUT_ENABLE_ACCESS_DELAY_NS)
     + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_WAIT_CYC =
    (DATA_SETUP_INTERVAL_NS + WRITE_TO_HIGHZ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STORE_REQ_CYC = (STORE_REQUEST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STORE_TIME_CYC = STORE_TIME_MS * CLK_MHZ * 1000;
  localparam int CNT_W = 20;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_READ  = 3'b001,
    ST_WRITE = 3'b010,
    ST_GAP   = 3'b011,
    ST_REQ   = 3'b100,
    ST_BUSY  = 3'b101
  } host_state_e;
endpackage : nvsram_host_pkg

// *** rtl/nvsram_wait_timer.sv ***
// down-counting wait timer that pulses done when a loaded count runs out
`timescale 1ns/100ps
`default_nettype none
module nvsram_wait_timer
  import nvsram_host_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control
  input wire logic load,
  input wire logic [CNT_W-1:0] count,
  output logic done,
  output logic running
);
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      done <= 1'b0;
    end else if (load) begin
      cnt_q <= count;
      done <= 1'b0;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
      done <= (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
    end else begin
      done <= 1'b0;
    end
  end

  assign running = (cnt_q != '0);
endmodule : nvsram_wait_timer
`default_nettype wire

// *** tb/nvsram_dev_model.sv ***
// behavioural model of the non-volatile static memory seen from its pins
`timescale 1ns/100ps
`default_nettype none
module nvsram_dev_model #(
  parameter int ACC_NS = 45,
  parameter int DLY_NS = 1000,
  parameter int STORE_NS = 50000
) (
  // strobes and address
  input wire logic select_n,
  input wire logic write_n,
  input wire logic out_en_n,
  input wire logic [10:0] byte_address,
  // data and store line
  input wire logic [7:0] host_data,
  input wire logic host_oe,
  input wire logic host_pull,
  input wire logic power_fail,
  output logic [7:0] dev_data,
  output logic busy_line_n
);
  logic [7:0] mem [2048];
  logic [7:0] nv [2048];
  logic [7:0] last_q = 8'h00;
  logic dirty = 1'b0;
  logic pull = 1'b0;
  logic armed = 1'b0;
  logic rd_on;
  // power-up recall fills the array from the shadow copy
  initial for (int i = 0; i < 2048; i++) begin
    nv[i] = i[7:0] ^ 8'hA5;
    mem[i] = nv[i];
  end
  assign busy_line_n = !(host_pull || pull);
  assign rd_on = !select_n && !out_en_n && write_n && busy_line_n;
  // a released bus shows the inverse of the last value
  assign #ACC_NS dev_data = rd_on ? mem[byte_address] : ~last_q;
  always @(negedge rd_on) last_q = dev_data;
  // a write needs a falling strobe while both are low
  always @(negedge select_n or negedge write_n) armed = busy_line_n && !select_n && !write_n;
  always @(posedge select_n or posedge write_n) begin
    if (armed && busy_line_n) begin
      mem[byte_address] = host_oe ? host_data : ~host_data;
      dirty = 1'b1;
    end
    armed = 1'b0;
  end
  // a power failure stores at once, with no request delay
  always @(posedge power_fail) if (dirty && !pull) begin
    pull = 1'b1;
    for (int i = 0; i < 2048; i++) nv[i] = mem[i];
    #STORE_NS pull = 1'b0;
    dirty = 1'b0;
  end
  // store runs only when written since the last store or recall
  always @(negedge busy_line_n) if (dirty && !pull) begin
    #DLY_NS pull = 1'b1;
    for (int i = 0; i < 2048; i++) nv[i] = mem[i];
    #STORE_NS pull = 1'b0;
    dirty = 1'b0;
  end
endmodule : nvsram_dev_model
`default_nettype wire

// *** tb/nvsram_host_tb_top.sv ***
// self-checking bench for the host controller of the non-volatile static memory
`timescale 1ns/100ps
`default_nettype none
module nvsram_host_tb_top;
  import nvsram_host_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic store_req = 1'b0;
  logic power_fail = 1'b0;
  logic req_ready, rsp_valid, store_active, select_n, write_n, out_en_n;
  logic data_bus_oe, store_busy_n_out, store_busy_n_oe, store_busy_n_in;
  logic [DATA_W-1:0] rsp_rdata, data_bus_out, dev_data, data_bus_in;
  logic [ADDR_W-1:0] byte_address;
  logic [DATA_W-1:0] exp_mem [2048];
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  assign data_bus_in = data_bus_oe ? data_bus_out : dev_data;
  nvsram_host nvsram_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .store_req(store_req),
    .store_active(store_active), .select_n(select_n), .write_n(write_n), .out_en_n(out_en_n),
    .byte_address(byte_address), .data_bus_in(data_bus_in), .data_bus_out(data_bus_out),
    .data_bus_oe(data_bus_oe), .store_busy_n_in(store_busy_n_in),
    .store_busy_n_out(store_busy_n_out), .store_busy_n_oe(store_busy_n_oe));
  nvsram_dev_model nvsram_dev_model_i (.select_n(select_n), .write_n(write_n),
    .out_en_n(out_en_n), .byte_address(byte_address), .host_data(data_bus_out),
    .host_oe(data_bus_oe), .host_pull(store_busy_n_oe && !store_busy_n_out),
    .power_fail(power_fail),
    .dev_data(dev_data), .busy_line_n(store_busy_n_in));
  function automatic logic [7:0] recall_val(input int a);
    return a[7:0] ^ 8'hA5;
  endfunction : recall_val
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("compares=%0d mismatches=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic access(input logic w, input logic [10:0] a, input logic [7:0] d);
    int n = 0;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    req_valid <= 1'b0;
    check(req_ready, 1'b1);
    n = 0;
    do begin
      if (!write_n) check({out_en_n, data_bus_oe, byte_address, data_bus_out}, {2'b11, a, d});
      else if (!out_en_n) check({data_bus_oe, byte_address}, {1'b0, a});
      @(posedge sys_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 50);
    check(rsp_valid, 1'b1);
    if (w) exp_mem[a] = d;
    else check(rsp_rdata, exp_mem[a]);
  endtask : access
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    logic [10:0] a;
    logic w;
    int n;
    void'($urandom(32'h1abefc43));
    for (int i = 0; i < 2048; i++) exp_mem[i] = recall_val(i);
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    check({select_n, write_n, out_en_n, data_bus_oe, store_busy_n_oe}, 5'h1C);
    $display("test reset done");
    @(posedge sys_clk);
    for (int i = 0; i < 60; i++) begin
      w = (i < 4) ? (i < 2) : 1'($urandom);
      a = (i < 4) ? (i[0] ? 11'h7FF : 11'h000) : 11'($urandom_range(0, 63));
      access(w, a, 8'($urandom));
    end
    $display("test access done");
    power_fail <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (store_active !== 1'b1 && n < 10);
    power_fail <= 1'b0;
    req_valid <= 1'b1;
    req_write <= 1'b1;
    check({store_busy_n_in, store_active, select_n}, 3'b011);
    for (int i = 0; i < 100; i++) begin
      @(posedge sys_clk);
      check({req_ready, select_n}, 2'b01);
    end
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (store_busy_n_in !== 1'b1 && n < 2200);
    check(store_busy_n_in, 1'b1);
    a = 11'($urandom_range(0, 63));
    access(1'b1, a, 8'($urandom));
    access(1'b0, a, 8'h00);
    $display("test power fail done");
    store_req <= 1'b1;
    req_valid <= 1'b1;
    req_write <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (store_active !== 1'b1 && n < 10);
    store_req <= 1'b0;
    check({store_busy_n_oe, store_busy_n_out, store_busy_n_in, store_active}, 4'b1001);
    for (int i = 0; i < 1100; i++) begin
      @(posedge sys_clk);
      check({req_ready, select_n}, 2'b01);
    end
    check({store_busy_n_oe, store_busy_n_out, store_busy_n_in, store_active}, 4'b0001);
    $display("test store done");
    end_of_test();
  end
endmodule : nvsram_host_tb_top
`default_nettype wire
